// *** src/dram_init_pkg.sv ***
// package: command codes, mode register layout, reset values and timing counts
package dram_init_pkg;
  localparam int unsigned CLK_MHZ = 125;
  // command codes on cmd_code
  localparam logic [2:0] CMD_NOP = 3'h0;
  localparam logic [2:0] CMD_MRW = 3'h1;
  localparam logic [2:0] CMD_MRR = 3'h2;
  localparam logic [2:0] CMD_MPC = 3'h3;
  localparam logic [2:0] CMD_ZQ_START = 3'h4;
  localparam logic [2:0] CMD_ZQ_LATCH = 3'h5;
  localparam logic [2:0] CMD_OTHER = 3'h6;
  // mode register addresses
  localparam logic [5:0] MR_FEATURE2 = 6'h02;
  localparam logic [5:0] MR_COMMAND_REFERENCE_LEVEL = 6'h0c;
  localparam logic [5:0] MR_REG_CTRL = 6'h0d;
  localparam logic [5:0] MR_VREF_DQ = 6'h0e;
  // field positions
  localparam int unsigned WL_EN_BIT = 7;
  localparam int unsigned CBT_BIT = 0;
  // reset values
  localparam logic [7:0] MR2_RST = 8'h00;
  localparam logic [7:0] MR13_RST = 8'h00;
  localparam logic [6:0] COMMAND_REFERENCE_LEVEL_RST = 7'h5d;
  localparam logic [6:0] VREF_DQ_RST = 7'h5d;
  localparam logic [5:0] DRIVE_CODE_RST = 6'h20;
  // impedance calibration interval, ns, and its count of cycles (least time, round up)
  localparam int unsigned ZQCAL_NS = 1000;
  localparam int unsigned ZQCAL_CYC = (ZQCAL_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned ZQ_CNT_W = 8;
endpackage

// *** src/zq_cal_if.sv ***
// interface: handshake between init sequencer and impedance calibration engine
`timescale 1ns/1ps
interface zq_cal_if;
  logic start;
  logic busy;
  logic done;
  logic [5:0] code;
  modport ctl (output start, input busy, input done, input code);
  modport eng (input start, output busy, output done, output code);
endinterface

// *** src/zq_cal_engine.sv ***
// impedance calibration engine: times the interval and holds the measured code
`timescale 1ns/1ps
module zq_cal_engine #(
  parameter logic [5:0] MEAS_CODE = 6'h2a
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  zq_cal_if.eng zq
);
  logic [dram_init_pkg::ZQ_CNT_W-1:0] cnt_r;
  logic busy_r;
  logic done_r;
  logic [5:0] code_r;
  wire last_w = busy_r && (cnt_r == dram_init_pkg::ZQ_CNT_W'(dram_init_pkg::ZQCAL_CYC - 1));

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      code_r <= dram_init_pkg::DRIVE_CODE_RST;
    end
    else
    begin
      if (zq.start && !busy_r)
      begin
        busy_r <= 1'b1;
        done_r <= 1'b0;
        cnt_r <= '0;
      end
      else if (last_w)
      begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
        code_r <= MEAS_CODE;
      end
      else if (busy_r)
        cnt_r <= cnt_r + 1'b1;
    end
  end

  assign zq.busy = busy_r;
  assign zq.done = done_r;
  assign zq.code = code_r;

  zq_interval_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(busy_r) |-> busy_r [*8] ##0 !done_r)
    else $error("calibration ended too early");
endmodule

// *** src/dram_init_device.sv ***
// device-side power-up and reset initialization logic
// Function
// - outputs stay high impedance while reset pin is low.
// - after latch command device applies calibrated drive and termination values.
// - in command bus training device echoes address bus on data bus.
// - power-up leaves receivers low speed with default reference levels.
// - write leveling mode follows mode register 2 bit 7.
// - after calibration latch and training device accepts any valid command.
`timescale 1ns/1ps
module dram_init_device (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic reset_pin_n,
  input wire logic cke,
  input wire logic cs,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic [5:0] mr_addr,
  input wire logic [7:0] mr_data,
  input wire logic [5:0] command_address_bus,
  input wire logic dqs_sample,
  input wire logic dq_train_done,
  output logic [15:0] dq_o,
  output logic dq_oe,
  output logic data_mask_invert_line_o,
  output logic data_mask_invert_line_oe,
  output logic [5:0] drive_code,
  output logic [5:0] term_code,
  output logic [6:0] command_reference_level,
  output logic [6:0] dq_reference_level,
  output logic receiver_low_speed,
  output logic cbt_active,
  output logic wl_active,
  output logic ready,
  output logic cmd_rejected
);
  typedef enum logic [3:0] {
    ST_RESET = 4'b0001,
    ST_CKE_LOW = 4'b0010,
    ST_BOOT = 4'b0100,
    ST_READY = 4'b1000
  } dev_state_t;

  dev_state_t state_r;
  dev_state_t state_nxt;
  logic [7:0] mr2_r;
  logic [7:0] mr13_r;
  logic [6:0] command_reference_level_r;
  logic [6:0] vref_dq_r;
  logic [5:0] drive_r;
  logic [5:0] term_r;
  logic low_speed_r;
  logic cbt_seen_r;
  logic latched_r;
  logic [15:0] dq_r;
  logic dq_oe_r;
  logic ready_r;
  logic rej_r;

  zq_cal_if zq ();
  zq_cal_engine u_zq (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .zq(zq)
  );

  // command decode
  wire in_reset_w = !reset_pin_n;
  wire cmd_w = cmd_valid && !in_reset_w && (state_r != ST_RESET) && (state_r != ST_CKE_LOW);
  wire mrw_w = cmd_w && (cmd_code == dram_init_pkg::CMD_MRW);
  wire mrr_w = cmd_w && (cmd_code == dram_init_pkg::CMD_MRR);
  wire zq_start_w = cmd_w && (cmd_code == dram_init_pkg::CMD_ZQ_START);
  wire zq_latch_w = cmd_w && (cmd_code == dram_init_pkg::CMD_ZQ_LATCH) && zq.done;
  // training commands are legal during boot, so only other commands wait for ready
  wire other_w = cmd_w && (cmd_code == dram_init_pkg::CMD_OTHER);
  wire cbt_w = mr13_r[dram_init_pkg::CBT_BIT];
  wire wl_w = mr2_r[dram_init_pkg::WL_EN_BIT];
  wire training_w = cbt_w || wl_w;
  // normal commands only once initialization has finished
  wire reject_w = other_w && (state_r != ST_READY);
  wire wr_mr2_w = mrw_w && (mr_addr == dram_init_pkg::MR_FEATURE2);
  wire wr_mr13_w = mrw_w && (mr_addr == dram_init_pkg::MR_REG_CTRL);
  wire wr_vca_w = mrw_w && (mr_addr == dram_init_pkg::MR_COMMAND_REFERENCE_LEVEL);
  wire wr_vdq_w = mrw_w && (mr_addr == dram_init_pkg::MR_VREF_DQ);
  wire [7:0] mrr_data_w =
    (mr_addr == dram_init_pkg::MR_FEATURE2) ? mr2_r :
    (mr_addr == dram_init_pkg::MR_REG_CTRL) ? mr13_r :
    (mr_addr == dram_init_pkg::MR_COMMAND_REFERENCE_LEVEL) ? {1'b0, command_reference_level_r} :
    (mr_addr == dram_init_pkg::MR_VREF_DQ) ? {1'b0, vref_dq_r} : 8'h00;
  wire go_ready_w = latched_r && cbt_seen_r && !training_w && dq_train_done;

  assign zq.start = zq_start_w;

  // state sequence
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RESET: if (reset_pin_n) state_nxt = ST_CKE_LOW;
      ST_CKE_LOW: if (cke && !cs) state_nxt = ST_BOOT;
      ST_BOOT: if (go_ready_w) state_nxt = ST_READY;
      ST_READY: state_nxt = ST_READY;
      default: state_nxt = ST_RESET;
    endcase
    if (in_reset_w)
      state_nxt = ST_RESET;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      state_r <= ST_RESET;
    else
      state_r <= state_nxt;
  end

  // mode registers and receiver setup, restored on every reset
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || in_reset_w)
    begin
      mr2_r <= dram_init_pkg::MR2_RST;
      mr13_r <= dram_init_pkg::MR13_RST;
      command_reference_level_r <= dram_init_pkg::COMMAND_REFERENCE_LEVEL_RST;
      vref_dq_r <= dram_init_pkg::VREF_DQ_RST;
      low_speed_r <= 1'b1;
      cbt_seen_r <= 1'b0;
    end
    else
    begin
      if (wr_mr2_w)
        mr2_r <= mr_data;
      if (wr_mr13_w)
        mr13_r <= mr_data;
      if (wr_vca_w)
        command_reference_level_r <= mr_data[6:0];
      if (wr_vdq_w)
        vref_dq_r <= mr_data[6:0];
      if (cbt_w)
        cbt_seen_r <= 1'b1;
      if (state_nxt == ST_READY)
        low_speed_r <= 1'b0;
    end
  end

  // calibrated values take effect only on the latch command
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || in_reset_w)
    begin
      drive_r <= dram_init_pkg::DRIVE_CODE_RST;
      term_r <= dram_init_pkg::DRIVE_CODE_RST;
      latched_r <= 1'b0;
    end
    else if (zq_latch_w)
    begin
      drive_r <= zq.code;
      term_r <= zq.code;
      latched_r <= 1'b1;
    end
  end

  // data bus drive: high impedance in reset, training echo, read data
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || in_reset_w)
    begin
      dq_r <= 16'h0000;
      dq_oe_r <= 1'b0;
    end
    else if (cbt_w)
    begin
      dq_r <= {10'h000, command_address_bus};
      dq_oe_r <= 1'b1;
    end
    else if (wl_w)
    begin
      dq_r <= {16{dqs_sample}};
      dq_oe_r <= 1'b1;
    end
    else if (mrr_w)
    begin
      dq_r <= {8'h00, mrr_data_w};
      dq_oe_r <= 1'b1;
    end
    else
    begin
      dq_r <= 16'h0000;
      dq_oe_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst || in_reset_w)
    begin
      ready_r <= 1'b0;
      rej_r <= 1'b0;
    end
    else
    begin
      ready_r <= (state_nxt == ST_READY);
      rej_r <= reject_w;
    end
  end

  assign dq_o = dq_r;
  assign dq_oe = dq_oe_r;
  assign data_mask_invert_line_o = 1'b0;
  assign data_mask_invert_line_oe = 1'b0;
  assign drive_code = drive_r;
  assign term_code = term_r;
  assign command_reference_level = command_reference_level_r;
  assign dq_reference_level = vref_dq_r;
  assign receiver_low_speed = low_speed_r;
  assign cbt_active = mr13_r[dram_init_pkg::CBT_BIT];
  assign wl_active = mr2_r[dram_init_pkg::WL_EN_BIT];
  assign ready = ready_r;
  assign cmd_rejected = rej_r;

  sequence reset_held_s;
    !reset_pin_n ##1 !reset_pin_n;
  endsequence

  hiz_in_reset_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    reset_held_s |-> !dq_oe && !data_mask_invert_line_oe)
    else $error("outputs driven during reset");

  latch_apply_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    zq_latch_w && reset_pin_n |=> drive_code == $past(zq.code) && term_code == drive_code)
    else $error("calibrated code not applied");

  no_early_apply_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !zq_latch_w && reset_pin_n |=> $stable(drive_code) || !$past(reset_pin_n))
    else $error("drive code changed without latch");

  cbt_echo_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    cbt_active && reset_pin_n |=> dq_oe && dq_o[5:0] == $past(command_address_bus))
    else $error("training echo wrong");

  boot_defaults_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $past(!reset_pin_n) && !reset_pin_n |-> receiver_low_speed &&
      command_reference_level == dram_init_pkg::COMMAND_REFERENCE_LEVEL_RST)
    else $error("receiver defaults not restored");

  wl_follow_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    wr_mr2_w && reset_pin_n |=> wl_active == $past(mr_data[7]))
    else $error("write leveling mode not following bit");

  ready_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    other_w && !ready && state_r != ST_READY && reset_pin_n |=> cmd_rejected)
    else $error("command accepted before ready");
endmodule

// *** test/ctl_model.sv ***
// controller model: reset pin, clock enable and chip select through power-up
`timescale 1ns/1ps
module ctl_model #(
  parameter int RST_HOLD = 25,
  parameter int CKE_WAIT = 25,
  parameter int IDLE_WAIT = 250
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic start_seq,
  output logic reset_pin_n,
  output logic cke,
  output logic cs,
  output logic seq_done
);
  int cnt = 0;
  int step = 0;
  int lim;
  // reset low for the hold count, then clock enable low for its own count
  // hold counts are shortened to keep runs brief; the device does not time them
  assign reset_pin_n = (step != 0);
  assign cke = (step >= 2);
  assign cs = 1'b0;
  assign seq_done = (step == 3);
  assign lim = (step == 0) ? RST_HOLD : (step == 1) ? CKE_WAIT : IDLE_WAIT;
  always @(posedge core_clk)
  begin
    if (sys_rst || start_seq)
    begin
      step <= 0;
      cnt <= 0;
    end
    else if (step < 3)
    begin
      cnt <= cnt + 1;
      if (cnt == lim)
      begin
        step <= step + 1;
        cnt <= 0;
      end
    end
  end
endmodule

// *** test/tb_dram_powerup_init_sequence.sv ***
// testbench: power-up, mode accesses, calibration, training, stable-power reset
`timescale 1ns/1ps
module tb_dram_powerup_init_sequence;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic start_seq = 1'b0;
  logic reset_pin_n, cke, cs, seq_done;
  logic cmd_valid = 1'b0;
  logic [2:0] cmd_code = 3'h0;
  logic [5:0] mr_addr = 6'h00;
  logic [7:0] mr_data = 8'h00;
  logic [5:0] cab = 6'h00;
  logic dqs = 1'b0;
  logic dtd = 1'b0;
  logic [15:0] dq_o;
  logic dq_oe, low_spd, cbt, wl, ready, rej;
  logic dmi_o, dmi_oe;
  logic [5:0] drv, term;
  logic [6:0] vca, vdq;
  logic [7:0] v;
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int mr [64];
  ctl_model ctl (.core_clk(core_clk), .sys_rst(sys_rst), .start_seq(start_seq),
    .reset_pin_n(reset_pin_n), .cke(cke), .cs(cs), .seq_done(seq_done));
  dram_init_device dut (.core_clk(core_clk), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n),
    .cke(cke), .cs(cs), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .mr_addr(mr_addr),
    .mr_data(mr_data), .command_address_bus(cab), .dqs_sample(dqs), .dq_train_done(dtd),
    .dq_o(dq_o), .dq_oe(dq_oe), .data_mask_invert_line_o(dmi_o),
    .data_mask_invert_line_oe(dmi_oe),
    .drive_code(drv), .term_code(term), .command_reference_level(vca),
    .dq_reference_level(vdq), .receiver_low_speed(low_spd), .cbt_active(cbt),
    .wl_active(wl), .ready(ready), .cmd_rejected(rej));
  initial
  begin
    forever #4 core_clk = ~core_clk;
  end
  task automatic report_and_stop();
    if (num_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // model of the mode registers after any reset
  task automatic rst_chk();
    for (int i = 0; i < 64; i++)
      mr[i] = 0;
    mr[12] = 8'h5d;
    mr[14] = 8'h5d;
    chk({dmi_oe, dmi_o, dq_oe, ready, low_spd}, 16'h0001);
    chk({drv, term}, {4'h0, 6'h20, 6'h20});
    chk({vca, vdq}, {2'h0, 7'h5d, 7'h5d});
  endtask
  task automatic cmd(input logic [2:0] c, input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    mr_addr <= a;
    mr_data <= d;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    #1;
    if (c == dram_init_pkg::CMD_MRW)
      mr[a] = d;
  endtask
  task automatic rd(input logic [5:0] a);
    cmd(dram_init_pkg::CMD_MRR, a, 8'h00);
    chk({dq_oe, dq_o[7:0]}, {7'h0, 1'b1, 8'(mr[a])});
  endtask
  // feed random bus values, expect the prior cycle's value echoed
  task automatic train(input bit cb);
    logic [5:0] q[$];
    logic [5:0] r;
    logic [5:0] e;
    q.push_back(cb ? cab : {5'h0, dqs});
    repeat (20)
    begin
      r = 6'($urandom);
      @(posedge core_clk);
      cab <= r;
      dqs <= r[0];
      #1;
      e = q.pop_front();
      if (cb)
        chk({dq_oe, dq_o[5:0]}, {9'h0, 1'b1, e});
      else
        chk(dq_o, {16{e[0]}});
      q.push_back(cb ? r : {5'h0, r[0]});
    end
  endtask
  initial
  begin
    void'($urandom(59));
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (5) @(posedge core_clk);
    #1;
    rst_chk();
    wait (seq_done === 1'b1);
    rd(6'h0c);
    rd(6'h0e);
    rd(6'h05);
    v = 8'($urandom) & 8'h7f;
    cmd(dram_init_pkg::CMD_MRW, 6'h0c, v);
    chk(vca, v[6:0]);
    rd(6'h0c);
    v = 8'($urandom) & 8'h7f;
    cmd(dram_init_pkg::CMD_MRW, 6'h0e, v);
    chk(vdq, v[6:0]);
    rd(6'h0e);
    cmd(dram_init_pkg::CMD_MPC, 6'h00, 8'h00);
    chk(rej, 1'b0);
    cmd(dram_init_pkg::CMD_OTHER, 6'h00, 8'h00);
    chk(rej, 1'b1);
    cmd(dram_init_pkg::CMD_ZQ_LATCH, 6'h00, 8'h00);
    chk(drv, 6'h20);
    cmd(dram_init_pkg::CMD_ZQ_START, 6'h00, 8'h00);
    repeat (dram_init_pkg::ZQCAL_CYC + 5) @(posedge core_clk);
    chk(drv, 6'h20);
    cmd(dram_init_pkg::CMD_ZQ_LATCH, 6'h00, 8'h00);
    chk({drv, term}, {6'h2a, 6'h2a});
    cmd(dram_init_pkg::CMD_MRW, 6'h0d, 8'h01);
    chk(cbt, 1'b1);
    train(1'b1);
    cmd(dram_init_pkg::CMD_MRW, 6'h0d, 8'h00);
    cmd(dram_init_pkg::CMD_MRW, 6'h02, 8'h80);
    chk({cbt, wl}, 2'b01);
    train(1'b0);
    cmd(dram_init_pkg::CMD_MRW, 6'h02, 8'h00);
    chk({wl, ready}, 2'b00);
    @(posedge core_clk);
    dtd <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk({ready, low_spd}, 2'b10);
    cmd(dram_init_pkg::CMD_OTHER, 6'h00, 8'h00);
    chk(rej, 1'b0);
    @(posedge core_clk);
    start_seq <= 1'b1;
    @(posedge core_clk);
    start_seq <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    rst_chk();
    wait (seq_done === 1'b1);
    rd(6'h0c);
    cmd(dram_init_pkg::CMD_OTHER, 6'h00, 8'h00);
    chk(rej, 1'b1);
    report_and_stop();
  end
endmodule
